/* smp_pkg.sv */
// Purpose: Shared constants and types of the serial peripheral port.
// Assumes: APB byte addresses, 32-bit data, one aligned word per register.
// Notes:   Field positions are bit indices into control and status words.
`default_nettype none

package smp_pkg;

  // ==========================================================
  // Register map
  localparam logic [31:0] ADDR_STATUS  = 32'hFFFF0A00;
  localparam logic [31:0] ADDR_RXDATA  = 32'hFFFF0A04;
  localparam logic [31:0] ADDR_TXDATA  = 32'hFFFF0A08;
  localparam logic [31:0] ADDR_DIVIDER = 32'hFFFF0A0C;
  localparam logic [31:0] ADDR_CONTROL = 32'hFFFF0A10;

  // ==========================================================
  // Reset values and masks
  localparam logic [7:0]  DATA_RST   = 8'h00;
  localparam logic [7:0]  DIV_RST    = 8'h1B;
  localparam logic [15:0] CTRL_RST   = 16'h0000;
  localparam logic [15:0] CTRL_WMASK = 16'h1FEF;

  // ==========================================================
  // Control bit positions
  localparam int C_EN     = 0;
  localparam int C_MST    = 1;
  localparam int C_CPHA   = 2;
  localparam int C_CPOL   = 3;
  localparam int C_LSB    = 5;
  localparam int C_TXMODE = 6;
  localparam int C_UNFZ   = 7;
  localparam int C_OVWR   = 8;
  localparam int C_CSEN   = 9;
  localparam int C_SOEN   = 10;
  localparam int C_LOOP   = 11;
  localparam int C_CONT   = 12;

  // ==========================================================
  // Status bit positions
  localparam int S_TXF   = 0;
  localparam int S_TXIRQ = 1;
  localparam int S_TXUNF = 2;
  localparam int S_RXF   = 3;
  localparam int S_RXIRQ = 4;
  localparam int S_RXOVF = 5;

  // ==========================================================
  // Timing counts
  localparam logic [3:0] HALF_LAST  = 4'hF;  // 16 half bits per byte
  localparam logic [3:0] STALL_LAST = 4'h1;  // 2 idle half bits
  localparam logic [3:0] BIT_LAST   = 4'h7;  // eighth sample ends a byte

  typedef enum logic [1:0] {SMP_IDLE, SMP_XFER, SMP_STALL} smp_state_t;

endpackage

`default_nettype wire

/* smp_sync.sv */
// Purpose: Two-flop synchroniser bank for the serial pins.
// Assumes: Inputs are asynchronous to clk.
// Notes:   Only the second flop of each bit is visible outside.
`timescale 1ns/1ns
`default_nettype none

module smp_sync
  import smp_pkg::*;
#(
  parameter int unsigned   W   = 1,
  parameter logic [W-1:0]  RST = '0
) (
  input  wire logic          clk,
  input  wire logic          rst_n,
  input  wire logic [W-1:0]  d,
  output var  logic [W-1:0]  q
);

  logic [W-1:0] meta;

  // ==========================================================
  // One two-stage chain per bit
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          meta[i] <= RST[i];
          q[i]    <= RST[i];
        end else begin
          meta[i] <= d[i];
          q[i]    <= meta[i];
        end
      end
    end
  endgenerate

endmodule // smp_sync

`default_nettype wire

/* smp_port.sv */
// Purpose: Full-duplex 8-bit serial port, master or slave, on APB.
// Assumes: pclk is the undivided core clock; serial pins are asynchronous.
// Notes:   Slave clock must stay below pclk/4; zero-wait APB access.
`timescale 1ns/1ns
`default_nettype none

module smp_port
  import smp_pkg::*;
(
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [31:0]  paddr,
  input  wire logic [31:0]  pwdata,
  output var  logic [31:0]  prdata,
  output logic              pready,
  output var  logic         pslverr,
  input  wire logic         sclk_in,
  output logic              sclk_out,
  output logic              sclk_oe,
  input  wire logic         mosi_in,
  output logic              mosi_out,
  output logic              mosi_oe,
  input  wire logic         miso_in,
  output logic              miso_out,
  output logic              miso_oe,
  input  wire logic         cs_n_in,
  output logic              cs_n_out,
  output logic              cs_n_oe,
  output logic              irq
);

  // ==========================================================
  // State
  logic [15:0] ctrl;
  logic [7:0]  div;
  logic [7:0]  tx_data;
  logic [7:0]  last_tx;
  logic [7:0]  rx_data;
  logic [7:0]  sh;
  logic [7:0]  rx_sh;
  logic [7:0]  cnt;
  logic [3:0]  hc;
  logic [3:0]  bit_cnt;
  logic        tx_full;
  logic        tx_unf;
  logic        rx_full;
  logic        rx_ovf;
  logic        rd_pend;
  logic        sclk_d;
  logic        cs_d;
  smp_state_t  st;

  // ==========================================================
  // Pin synchronisers
  logic cs_s;
  logic sclk_s;
  logic mosi_s;
  logic miso_s;

  smp_sync #(.W(4), .RST(4'h8)) u_sync (
    .clk   (pclk),
    .rst_n (presetn),
    .d     ({cs_n_in, sclk_in, mosi_in, miso_in}),
    .q     ({cs_s, sclk_s, mosi_s, miso_s})
  );

  // ==========================================================
  // APB decode
  wire setup   = psel & ~penable;
  wire acc     = psel & penable;
  wire hit_sta = (paddr == ADDR_STATUS);
  wire hit_rxd = (paddr == ADDR_RXDATA);
  wire hit_txd = (paddr == ADDR_TXDATA);
  wire hit_div = (paddr == ADDR_DIVIDER);
  wire hit_ctl = (paddr == ADDR_CONTROL);
  wire mapped  = hit_sta | hit_rxd | hit_txd | hit_div | hit_ctl;
  wire wr_tx   = acc & pwrite & hit_txd;
  wire wr_div  = acc & pwrite & hit_div;
  wire wr_ctl  = acc & pwrite & hit_ctl;
  wire rd_rx   = acc & ~pwrite & hit_rxd;

  // Zero-wait answer in the access phase
  assign pready = acc;

  // ==========================================================
  // Mode decode
  wire en    = ctrl[C_EN];
  wire mst   = en & ctrl[C_MST];
  wire slv   = en & ~ctrl[C_MST];
  wire cpha  = ctrl[C_CPHA];
  wire cpol  = ctrl[C_CPOL];
  wire lsb   = ctrl[C_LSB];
  wire txmd  = ctrl[C_TXMODE];
  wire cont  = ctrl[C_CONT];
  wire xfer  = (st == SMP_XFER);

  // ==========================================================
  // Status flags
  // transmit interrupt flag
  wire tx_irq = en & (~tx_full | tx_unf);
  wire rx_irq = rx_full | rx_ovf;
  logic [7:0] status;

  always_comb begin
    status          = DATA_RST;
    status[S_TXF]   = tx_full;
    status[S_TXIRQ] = tx_irq;
    status[S_TXUNF] = tx_unf;
    status[S_RXF]   = rx_full;
    status[S_RXIRQ] = rx_irq;
    status[S_RXOVF] = rx_ovf;
  end

  // one flag chosen by transfer mode
  assign irq = txmd ? tx_irq : rx_irq;

  // Read data selection; transmit data reads zero
  wire [31:0] rd_mux = hit_sta ? {24'h000000, status}  :
                       hit_rxd ? {24'h000000, rx_data} :
                       hit_div ? {24'h000000, div}     :
                       hit_ctl ? {16'h0000, ctrl}      : 32'h00000000;

  // ==========================================================
  // Master bit timing
  // half bit lasts div+1 cycles
  wire tick     = (cnt == div);
  wire m_go     = mst & (st == SMP_IDLE) & (txmd ? tx_full : rd_pend);
  wire m_sample = xfer & tick & ~hc[0];
  wire m_done   = xfer & tick & (hc == HALF_LAST);
  wire m_shift  = xfer & tick & hc[0] & ~m_done;
  // continuous transfer reloads without releasing select
  wire m_again  = m_done & cont & tx_full;

  // ==========================================================
  // Slave edge detection
  // slave active while select is low
  wire s_act   = slv & ~cs_s;
  wire s_start = s_act & cs_d;
  wire s_edge  = s_act & (sclk_s != sclk_d);
  wire s_lead  = s_edge & (sclk_s != cpol);
  wire s_trail = s_edge & (sclk_s == cpol);
  // sample and drive on opposite edges
  wire s_sample = cpha ? s_trail : s_lead;
  wire s_shift  = (cpha ? s_lead : s_trail) & (bit_cnt != 4'h0);

  // ==========================================================
  // Shared shifter
  wire sample    = m_sample | s_sample;
  wire shift     = m_shift | s_shift;
  wire byte_done = sample & (bit_cnt == BIT_LAST);
  wire load      = m_go | m_again | s_start | (s_act & byte_done);
  // loopback ties master input to output
  wire ser_in    = mst ? (ctrl[C_LOOP] ? mosi_out : miso_s) : mosi_s;
  wire ser_out   = lsb ? sh[0] : sh[7];
  wire [7:0] rx_byte = lsb ? {ser_in, rx_sh[7:1]} : {rx_sh[6:0], ser_in};
  wire [7:0] next_tx_byte = tx_full ? tx_data :
                            (ctrl[C_UNFZ] ? DATA_RST : last_tx);
  wire [7:0] next_sh = lsb ? {1'b0, sh[7:1]} : {sh[6:0], 1'b0};
  // overflow keeps or drops the new byte
  wire rx_take = ~rx_full | rd_rx | ctrl[C_OVWR];

  // ==========================================================
  // Flag next values; a set wins over a same-cycle clear
  // full on write, cleared when taken
  wire next_tx_full = wr_tx | (tx_full & ~load);
  // underflow on empty load, cleared by write
  wire next_tx_unf  = (load & ~tx_full) | (tx_unf & ~wr_tx);
  wire next_rx_full = byte_done | (rx_full & ~rd_rx);
  wire next_rx_ovf  = (byte_done & rx_full & ~rd_rx) | (rx_ovf & ~rd_rx);

  // ==========================================================
  // Pin drive
  // idle level; phase picks active half
  assign sclk_out = cpol ^ (xfer & (hc[0] ^ cpha));
  assign sclk_oe  = mst;
  assign mosi_out = ser_out;
  assign mosi_oe  = mst;
  assign miso_out = ser_out;
  assign miso_oe  = s_act & ctrl[C_SOEN];
  assign cs_n_out = ~xfer;
  assign cs_n_oe  = mst & ctrl[C_CSEN];

  // ==========================================================
  // APB registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (setup) begin
      prdata  <= rd_mux;
      pslverr <= ~mapped;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= CTRL_RST;
      div  <= DIV_RST;
    end else begin
      if (wr_ctl) ctrl <= pwdata[15:0] & CTRL_WMASK;
      if (wr_div) div  <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_data <= DATA_RST;
      rx_data <= DATA_RST;
    end else begin
      if (wr_tx) tx_data <= pwdata[7:0];
      if (byte_done && rx_take) rx_data <= rx_byte;
    end
  end

  // Status flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_full <= 1'b0;
      tx_unf  <= 1'b0;
      rx_full <= 1'b0;
      rx_ovf  <= 1'b0;
    end else begin
      tx_full <= next_tx_full;
      tx_unf  <= next_tx_unf;
      rx_full <= next_rx_full;
      rx_ovf  <= next_rx_ovf;
    end
  end

  // receive read requests a master transfer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) rd_pend <= 1'b0;
    else          rd_pend <= (rd_rx & mst & ~txmd) | (rd_pend & ~m_go & mst);
  end

  // ==========================================================
  // Master sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st  <= SMP_IDLE;
      hc  <= 4'h0;
      cnt <= 8'h00;
    end else if (!mst) begin
      st  <= SMP_IDLE;
      hc  <= 4'h0;
      cnt <= 8'h00;
    end else begin
      cnt <= (st == SMP_IDLE || tick) ? 8'h00 : cnt + 8'h01;
      case (st)
        SMP_IDLE: begin
          hc <= 4'h0;
          if (m_go) st <= SMP_XFER;
        end
        SMP_XFER: begin
          if (m_done) begin
            hc <= 4'h0;
            if (!m_again) st <= SMP_STALL;
          end else if (tick) begin
            hc <= hc + 4'h1;
          end
        end
        SMP_STALL: begin
          if (tick) begin
            hc <= hc + 4'h1;
            if (hc == STALL_LAST) st <= SMP_IDLE;
          end
        end
        default: st <= SMP_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Shift registers and bit count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sh      <= DATA_RST;
      last_tx <= DATA_RST;
      rx_sh   <= DATA_RST;
      bit_cnt <= 4'h0;
    end else begin
      if (load) begin
        sh      <= next_tx_byte;
        last_tx <= next_tx_byte;
      end else if (shift) begin
        sh <= next_sh;
      end
      if (sample) rx_sh <= rx_byte;
      if (load || byte_done || !(xfer || s_act)) bit_cnt <= 4'h0;
      else if (sample)                          bit_cnt <= bit_cnt + 4'h1;
    end
  end

  // Slave edge history
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sclk_d <= 1'b0;
      cs_d   <= 1'b1;
    end else begin
      sclk_d <= sclk_s;
      cs_d   <= cs_s | ~slv;
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_overflow;
    byte_done && rx_full && !rd_rx;
  endsequence

  property p_rx_ovf_set;
    s_overflow |=> rx_ovf && rx_full;
  endproperty
  a_rx_ovf_set: assert property (p_rx_ovf_set)
    else $error("overflow flag not set");

  property p_rx_irq_clr;
    rd_rx && !byte_done |=> !rx_irq && !rx_full;
  endproperty
  a_rx_irq_clr: assert property (p_rx_irq_clr)
    else $error("receive flags not cleared by read");

  property p_rx_full_hold;
    rx_full && !rd_rx |=> rx_full && $stable(rx_data) || rx_ovf;
  endproperty
  a_rx_full_hold: assert property (p_rx_full_hold)
    else $error("receive data lost before read");

  property p_tx_unf;
    load && !tx_full && !wr_tx && !wr_ctl |=> tx_unf && tx_irq;
  endproperty
  a_tx_unf: assert property (p_tx_unf)
    else $error("underflow not flagged");

  sequence s_cont_end;
    m_done && cont && tx_full;
  endsequence

  property p_cont;
    s_cont_end |=> xfer && !cs_n_out && hc == 4'h0;
  endproperty
  a_cont: assert property (p_cont)
    else $error("continuous transfer dropped select");

  sequence s_single_end;
    m_done && !cont && mst;
  endsequence

  property p_stall;
    s_single_end ##1 mst |-> cs_n_out && st == SMP_STALL;
  endproperty
  a_stall: assert property (p_stall)
    else $error("no stall after single byte");

  property p_clk_idle;
    !xfer |-> sclk_out == cpol;
  endproperty
  a_clk_idle: assert property (p_clk_idle)
    else $error("serial clock not at idle level");

  property p_half_len;
    xfer && tick && !m_done && $stable(div) && !wr_div && div != 8'h00
      |=> !tick[*1] ##0 cnt == 8'h00;
  endproperty
  a_half_len: assert property (p_half_len)
    else $error("half bit counter not restarted");

  property p_tx_take;
    wr_tx |=> tx_full && tx_data == $past(pwdata[7:0]);
  endproperty
  a_tx_take: assert property (p_tx_take)
    else $error("transmit write not captured");

endmodule // smp_port

`default_nettype wire

/* smp_peer.sv */
// Purpose: Behavioural serial peer that answers the port in master mode.
// Assumes: Clock polarity and phase are told by the bench.
// Notes:   Data line shows no stale bit while deselected.
`timescale 1ns/1ns
`default_nettype none

module smp_peer (
  input  wire logic       sclk,
  input  wire logic       cs_n,
  input  wire logic       mosi,
  input  wire logic       cpol,
  input  wire logic       cpha,
  input  wire logic [7:0] tx_byte,
  output var  logic       miso,
  output var  logic [7:0] rx_byte
);
  int n = 0;
  logic lead;

  // ==========================================================
  // Select edges
  initial miso = 1'b0;
  always @(cs_n) begin
    n = 0;
    if (!cs_n) miso = tx_byte[7];
    if (cs_n) miso = ~miso;
  end

  // ==========================================================
  // Shift on one edge, sample on the other
  // edge pairing; bytes wrap while select stays low
  always @(sclk) if (!cs_n) begin
    lead = (sclk != cpol);
    if (lead == !cpha) begin
      rx_byte = {rx_byte[6:0], mosi};
      n = n + 1;
    end else miso = tx_byte[7 - (n % 8)];
  end
endmodule // smp_peer

`default_nettype wire

/* testbench.sv */
// Purpose: Self-checking bench for the serial port over APB.
// Assumes: Zero-wait APB slave, peer model on the serial side.
// Notes:   Loopback, external peer and slave mode are all exercised.
`timescale 1ns/1ns
`default_nettype none

module testbench
  import smp_pkg::*;
;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [31:0] paddr = '0, pwdata = '0, prdata, r;
  logic        pready, pslverr, sclk_out, sclk_oe, mosi_out, mosi_oe;
  logic        miso_out, miso_oe, cs_n_out, cs_n_oe, irq, miso_peer;
  logic        sclk_in = 0, mosi_in = 0, cs_n_in = 1, cpol = 0, cpha = 0;
  logic [7:0]  peer_tx = 8'h1D, peer_rx, sb, mo = 8'hC3;
  logic [4:0]  md [5] = '{5'h00, 5'h04, 5'h08, 5'h0C, 5'h20};
  int          failures = 0, check_count = 0;
  time         t0;

  always #25 pclk = ~pclk;

  smp_port u_smp_port (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sclk_in(sclk_in), .sclk_out(sclk_out), .sclk_oe(sclk_oe),
    .mosi_in(mosi_in), .mosi_out(mosi_out), .mosi_oe(mosi_oe), .miso_in(miso_peer),
    .miso_out(miso_out), .miso_oe(miso_oe), .cs_n_in(cs_n_in), .cs_n_out(cs_n_out),
    .cs_n_oe(cs_n_oe), .irq(irq));

  smp_peer u_smp_peer (.sclk(sclk_oe ? sclk_out : cpol), .cs_n(cs_n_oe ? cs_n_out : 1'b1),
    .mosi(mosi_out), .cpol(cpol), .cpha(cpha), .tx_byte(peer_tx), .miso(miso_peer),
    .rx_byte(peer_rx));

  // ==========================================================
  // Compare, bus cycles and polling
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) failures++;
    r = prdata;
    psel <= 0; penable <= 0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] exp);
    apb(1'b0, a, '0);
    check(r, exp);
  endtask

  task automatic poll(input int b);
    int n;
    n = 0;
    do begin
      apb(1'b0, ADDR_STATUS, '0);
      n++;
    end while (r[b] !== 1'b1 && n < 100);
    if (n >= 100) failures++;
  endtask

  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ==========================================================
  // Watchdog
  initial begin
    #2000000;
    failures++;
    print_verdict();
  end

  // ==========================================================
  // Test sequence
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    rd(ADDR_DIVIDER, 32'h1B);
    rd(ADDR_CONTROL, 32'h0);
    rd(ADDR_STATUS, 32'h0);
    rd(ADDR_RXDATA, 32'h0);
    rd(ADDR_TXDATA, 32'h0);
    apb(1'b0, 32'hFFFF0A20, '0);
    check(pslverr, 1'b1);
    wr(ADDR_CONTROL, 32'hFFFF);
    rd(ADDR_CONTROL, 32'h1FEF);
    wr(ADDR_DIVIDER, 32'h03);
    rd(ADDR_DIVIDER, 32'h03);
    // External peer in every clock mode, one byte each
    foreach (md[i]) begin
      cpol <= md[i][3]; cpha <= md[i][2];
      wr(ADDR_CONTROL, 32'h0243 | md[i]);
      check(sclk_oe & mosi_oe, 1'b1);
      wr(ADDR_TXDATA, 32'h61);
      check(pslverr, 1'b0);
      if (i == 0) begin
        @(posedge sclk_out);
        t0 = $time;
        @(posedge sclk_out);
        check(32'($time - t0), 32'h190);
      end
      poll(S_RXF);
      check(peer_rx, md[i][4] ? 8'h86 : 8'h61);
      rd(ADDR_RXDATA, md[i][4] ? 32'hB8 : 32'h1D);
    end
    // Continuous transfer keeps select low across two queued bytes
    wr(ADDR_CONTROL, 32'h1243);
    wr(ADDR_TXDATA, 32'h5A);
    poll(S_TXIRQ);
    wr(ADDR_TXDATA, 32'hA5);
    poll(S_RXF);
    check(peer_rx, 8'h5A);
    rd(ADDR_RXDATA, 32'h1D);
    check(cs_n_out, 1'b0);
    poll(S_RXF);
    check(peer_rx, 8'hA5);
    rd(ADDR_RXDATA, 32'h1D);
    // Loopback overflow, drop then overwrite
    wr(ADDR_CONTROL, 32'h0A43);
    check(cs_n_oe, 1'b1);
    wr(ADDR_TXDATA, 32'h11);
    poll(S_RXF);
    wr(ADDR_TXDATA, 32'h22);
    poll(S_RXOVF);
    rd(ADDR_STATUS, 32'h3A);
    check(irq, 1'b1);
    rd(ADDR_RXDATA, 32'h11);
    rd(ADDR_STATUS, 32'h02);
    wr(ADDR_CONTROL, 32'h0943);
    check(cs_n_oe, 1'b0);
    wr(ADDR_TXDATA, 32'h33);
    poll(S_RXF);
    wr(ADDR_TXDATA, 32'h44);
    poll(S_RXOVF);
    rd(ADDR_RXDATA, 32'h44);
    // Read-started transfers with empty transmit register
    wr(ADDR_CONTROL, 32'h0A03);
    rd(ADDR_RXDATA, 32'h44);
    poll(S_RXF);
    rd(ADDR_STATUS, 32'h1E);
    check(irq, 1'b1);
    wr(ADDR_CONTROL, 32'h0A83);
    rd(ADDR_RXDATA, 32'h44);
    poll(S_RXF);
    wr(ADDR_CONTROL, 32'h0A43);
    rd(ADDR_RXDATA, 32'h00);
    // Slave mode driven by the bench as external master
    wr(ADDR_CONTROL, 32'h0401);
    check({29'h0, sclk_oe, mosi_oe, cs_n_oe}, 32'h0);
    wr(ADDR_TXDATA, 32'h96);
    rd(ADDR_STATUS, 32'h01);
    cs_n_in <= 0;
    repeat (6) @(posedge pclk);
    check(miso_oe, 1'b1);
    for (int i = 7; i >= 0; i--) begin
      mosi_in <= mo[i];
      repeat (5) @(posedge pclk);
      sb[i] = miso_out;
      sclk_in <= 1;
      repeat (5) @(posedge pclk);
      sclk_in <= 0;
    end
    repeat (5) @(posedge pclk);
    cs_n_in <= 1;
    poll(S_RXF);
    check(sb, 8'h96);
    rd(ADDR_RXDATA, 32'hC3);
    print_verdict();
  end
endmodule // testbench

`default_nettype wire
